// File: bench/msa_sfr_model.sv
// Special register responder standing in for the core and peripheral registers.
// Assumes it sees the first-space request in the cycle that the access unit takes it.
`timescale 1ns/1ps
module msa_sfr_model (
  // Clock
  input wire logic i_clk,
  // Request from the core
  input wire msa_pkg::msa_req_s i_req,
  // Register answer
  output logic o_hit,
  output logic [15:0] o_rdata
);
  logic [15:0] junk_r;
  initial junk_r = 16'hA5C3;
  // Registers implemented only in the lowest 64 bytes
  assign o_hit = i_req.valid && (i_req.ea[15:6] == 10'h000);
  // Unselected bus shows a changing pattern, never a tidy zero
  // Word decode only: both byte addresses of a word see the same value
  assign o_rdata = o_hit ? {{i_req.ea[7:1], 1'b0} ^ 8'h5A, i_req.ea[7:1], 1'b0} : junk_r;
  always @(posedge i_clk) begin
    junk_r <= ~junk_r + 16'h1357;
  end
endmodule

// File: bench/msa_top_test.sv
// Self-checking bench for the memory space access unit, random and corner cases.
// Assumes the package and the special register model are compiled before it.
`timescale 1ns/1ps
module msa_top_test;
  logic i_clk, i_srst, sfr_hit, pc_adv, pc_load, xrvalid, sfr_sel, sfr_we, win_req;
  logic yrvalid, aerr, aerr_wr, tcfg, tden, in_vec;
  msa_pkg::msa_req_s xreq, yreq, xr, yr;
  msa_pkg::msa_mod_s xmod, ymod;
  msa_pkg::msa_wop_e wop, op;
  msa_pkg::msa_preq_s preq, pr;
  logic [15:0] sfr_rdata, wreg_old, wreg_src, xrdata, xptr, yrdata, yptr, sfr_addr;
  logic [15:0] sfr_wdata, wreg_new, lfsr, m802, d, a, o, s;
  logic [22:0] pc_target;
  logic [14:0] win_off;
  logic [1:0] sfr_wstrb;
  logic [23:0] pc, taddr;
  int n_mismatch, check_count, cycles;

  msa_top u_msa_top (.i_clk(i_clk), .i_srst(i_srst), .i_xreq(xreq), .i_xmod(xmod),
    .i_yreq(yreq), .i_ymod(ymod), .i_sfr_rdata(sfr_rdata), .i_sfr_hit(sfr_hit),
    .i_wreg_old(wreg_old), .i_wreg_src(wreg_src), .i_wop(wop), .i_pc_adv(pc_adv),
    .i_pc_load(pc_load), .i_pc_target(pc_target), .i_preq(preq), .o_xrdata(xrdata),
    .o_xptr_next(xptr), .o_xrvalid(xrvalid), .o_sfr_sel(sfr_sel), .o_sfr_we(sfr_we),
    .o_sfr_wstrb(sfr_wstrb), .o_sfr_addr(sfr_addr), .o_sfr_wdata(sfr_wdata),
    .o_window_req(win_req), .o_window_off(win_off), .o_yrdata(yrdata),
    .o_yptr_next(yptr), .o_yrvalid(yrvalid), .o_wreg_new(wreg_new), .o_addr_err(aerr),
    .o_addr_err_wr(aerr_wr), .o_pc(pc), .o_taddr(taddr), .o_tcfg(tcfg),
    .o_tdenied(tden), .o_pc_in_vec(in_vec));
  msa_sfr_model u_msa_sfr_model (.i_clk(i_clk), .i_req(xreq), .o_hit(sfr_hit),
    .o_rdata(sfr_rdata));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic msa_pkg::msa_req_s rq(logic wr, logic bo, logic [15:0] ea,
                                           logic [15:0] wd, logic pi);
    return '{1'b1, wr, bo, 1'b0, ea, wd, 1'b0, 1'b0, pi};
  endfunction
  function automatic logic [15:0] wexp(msa_pkg::msa_wop_e p, logic [15:0] ov,
                                       logic [15:0] sv);
    case (p)
      msa_pkg::MSA_OP_SEXT: return {{8{sv[7]}}, sv[7:0]};
      msa_pkg::MSA_OP_ZEXT: return {8'h00, sv[7:0]};
      msa_pkg::MSA_OP_LDB: return {ov[15:8], sv[7:0]};
      default: return sv;
    endcase
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input msa_pkg::msa_req_s x, input msa_pkg::msa_req_s y);
    @(posedge i_clk);
    xreq <= x;
    yreq <= y;
    @(posedge i_clk);
    xreq <= '0;
    yreq <= '0;
    #1;
  endtask
  task automatic ctl(input msa_pkg::msa_wop_e p, input logic [15:0] ov,
                     input logic [15:0] sv, input logic adv, input logic ld,
                     input logic [22:0] t, input msa_pkg::msa_preq_s q);
    @(posedge i_clk);
    wop <= p;
    wreg_old <= ov;
    wreg_src <= sv;
    pc_adv <= adv;
    pc_load <= ld;
    pc_target <= t;
    preq <= q;
    @(posedge i_clk);
    wop <= msa_pkg::MSA_OP_NONE;
    pc_adv <= 1'b0;
    pc_load <= 1'b0;
    preq <= '0;
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    lfsr = 16'h0006;
    cycles = 0;
    i_srst = 1'b1;
    {xreq, yreq, xmod, ymod, preq} = '0;
    {wreg_old, wreg_src, pc_adv, pc_load, pc_target} = '0;
    wop = msa_pkg::MSA_OP_NONE;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk({pc, in_vec, aerr}, {24'h000000, 1'b1, 1'b0});
    $display("test reset done");
    d = rnd();
    acc(rq(1'b1, 1'b0, 16'h0800, d, 1'b0), '0);
    acc(rq(1'b1, 1'b1, 16'h0801, 16'h00AB, 1'b0), '0);
    acc(rq(1'b0, 1'b0, 16'h0800, 16'h0000, 1'b1), '0);
    chk({xrvalid, xrdata}, {1'b1, 8'hAB, d[7:0]});
    chk(xptr, 16'h0802);
    acc(rq(1'b0, 1'b1, 16'h0801, 16'h0000, 1'b1), '0);
    chk({xrdata, xptr}, {16'h00AB, 16'h0802});
    acc(rq(1'b0, 1'b1, 16'h0800, 16'h0000, 1'b0), '0);
    chk(xrdata, {8'h00, d[7:0]});
    $display("test lanes done");
    m802 = rnd();
    acc(rq(1'b1, 1'b0, 16'h0802, m802, 1'b0), '0);
    acc(rq(1'b1, 1'b0, 16'h0803, rnd(), 1'b0), '0);
    chk({aerr, aerr_wr, sfr_we}, 3'h6);
    @(posedge i_clk);
    #1;
    chk(aerr, 1'b0);
    acc(rq(1'b0, 1'b0, 16'h0803, 16'h0000, 1'b0), '0);
    chk({aerr, aerr_wr, xrvalid}, 3'h5);
    acc(rq(1'b0, 1'b0, 16'h0802, 16'h0000, 1'b0), '0);
    chk({aerr, xrdata}, {1'b0, m802});
    $display("test misaligned done");
    xr = rq(1'b0, 1'b0, 16'hE802, 16'h0000, 1'b0);
    xr.direct13 = 1'b1;
    acc(xr, '0);
    chk(xrdata, m802);
    d = rnd();
    acc(rq(1'b1, 1'b0, 16'h0A00, d, 1'b0), '0);
    acc(rq(1'b0, 1'b0, 16'h0802, 16'h0000, 1'b0), rq(1'b0, 1'b0, 16'h0A00, 16'h0000, 1'b1));
    chk({xrdata, yrdata, yrvalid, yptr}, {m802, d, 1'b1, 16'h0A02});
    @(posedge i_clk);
    xmod <= '{16'h0900, 16'h090F};
    ymod <= '{16'h0A00, 16'h0A07};
    xr = rq(1'b0, 1'b0, 16'h090E, 16'h0000, 1'b1);
    xr.modulo_en = 1'b1;
    yr = rq(1'b0, 1'b0, 16'h0A06, 16'h0000, 1'b1);
    yr.modulo_en = 1'b1;
    acc(xr, yr);
    chk({xptr, yptr}, {16'h0900, 16'h0A00});
    xr = rq(1'b1, 1'b0, 16'h0802, rnd(), 1'b1);
    xr.bitrev_en = 1'b1;
    yr = rq(1'b0, 1'b0, 16'h0A02, 16'h0000, 1'b1);
    yr.bitrev_en = 1'b1;
    acc(xr, yr);
    chk({xptr, yptr}, {16'h0812, 16'h0A04});
    $display("test dual done");
    for (int i = 0; i < 16; i++) begin
      a = 16'h0800 | (rnd() & 16'h03FE);
      d = rnd();
      acc(rq(1'b1, 1'b0, a, d, 1'b0), '0);
      acc(rq(1'b0, 1'b0, a, 16'h0000, 1'b0), '0);
      chk(xrdata, d);
    end
    acc(rq(1'b0, 1'b0, 16'h0C00, 16'h0000, 1'b0), '0);
    chk(xrdata, 16'h0000);
    acc(rq(1'b0, 1'b1, 16'h7FFF, 16'h0000, 1'b0), '0);
    chk(xrdata, 16'h0000);
    acc(rq(1'b0, 1'b0, 16'h8010, 16'h0000, 1'b0), '0);
    chk({win_req, win_off, xrdata}, {1'b1, 15'h0010, 16'h0000});
    acc(rq(1'b0, 1'b0, 16'h0700, 16'h0000, 1'b0), '0);
    chk(xrdata, 16'h0000);
    d = {8'h20 ^ 8'h5A, 8'h20};
    acc(rq(1'b0, 1'b0, 16'h0020, 16'h0000, 1'b0), '0);
    chk(xrdata, d);
    acc(rq(1'b0, 1'b1, 16'h0021, 16'h0000, 1'b0), '0);
    chk(xrdata, {8'h00, d[15:8]});
    acc(rq(1'b1, 1'b1, 16'h0021, 16'h00CD, 1'b0), '0);
    chk({sfr_sel, sfr_we, sfr_wstrb, sfr_addr, sfr_wdata},
        {1'b1, 1'b1, 2'h2, 16'h0020, 16'hCDCD});
    $display("test map done");
    for (int i = 0; i < 24; i++) begin
      o = rnd();
      s = rnd();
      op = msa_pkg::msa_wop_e'(3'(i % 4 + 1));
      ctl(op, o, s, 1'b0, 1'b0, 23'h000000, '0);
      chk(wreg_new, wexp(op, o, s));
    end
    $display("test wreg done");
    ctl(msa_pkg::MSA_OP_NONE, 16'h0000, 16'h0000, 1'b0, 1'b1, 23'h0001FC, '0);
    chk({pc, in_vec}, {24'h0001FC, 1'b1});
    for (int i = 1; i < 3; i++) begin
      ctl(msa_pkg::MSA_OP_NONE, 16'h0000, 16'h0000, 1'b1, 1'b0, 23'h000000, '0);
      chk({pc, in_vec}, {24'h0001FC + 24'(2 * i), i == 1});
    end
    for (int i = 0; i < 3; i++) begin
      pr = '{1'b1, i != 1, (i == 2) ? 8'h01 : 8'h80, rnd()};
      ctl(msa_pkg::MSA_OP_NONE, 16'h0000, 16'h0000, 1'b0, 1'b0, 23'h000000, pr);
      chk({tcfg, tden}, {i == 0, i == 1});
      if (pr.table_op) chk(taddr, {pr.page, pr.offset});
    end
    $display("test program done");
    complete_run();
  end
endmodule

// File: common/msa_pkg.sv
// Package for the memory space access unit: address map, widths, access types.
// Assumes a single core clock domain; no imports, every use is scoped.
package msa_pkg;
  localparam int EA_W = 16;
  localparam int DW = 16;
  localparam int PA_W = 24;
  localparam int RAM_BYTES = 1024;
  localparam int RAM_WORDS = RAM_BYTES / 2;
  localparam int RAM_AW = 9;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [15:0] SFR_LAST = 16'h07FF;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam int NEAR_W = 13;
  localparam int WINDOW_BIT = 15;
  localparam logic [15:0] XY_SPLIT = 16'h0A00;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [23:0] RESET_VEC = 24'h000000;
  localparam logic [23:0] IVT_LO = 24'h000004;
  localparam logic [23:0] IVT_HI = 24'h0000FF;
  localparam logic [23:0] AIVT_LO = 24'h000100;
  localparam logic [23:0] AIVT_HI = 24'h0001FF;
  localparam logic [23:0] VEC_END = 24'h000200;
  localparam logic [23:0] USER_LAST = 24'h7FFFFF;
  localparam int TABLE_PAGE_POINTER_CFG_BIT = 7;
  localparam int BITREV_W = 4;

  typedef enum logic [2:0] {
    MSA_OP_NONE = 3'h0,
    MSA_OP_SEXT = 3'h1,
    MSA_OP_ZEXT = 3'h2,
    MSA_OP_LDB = 3'h3,
    MSA_OP_LDW = 3'h4
  } msa_wop_e;

  // One data-space request from an address generator
  typedef struct packed {
    logic valid;
    logic wr;
    logic byte_op;
    logic direct13;
    logic [15:0] ea;
    logic [15:0] wdata;
    logic modulo_en;
    logic bitrev_en;
    logic post_inc;
  } msa_req_s;

  // Modulo window for an address generator
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] last;
  } msa_mod_s;

  // Program space request
  typedef struct packed {
    logic valid;
    logic table_op;
    logic [7:0] page;
    logic [15:0] offset;
  } msa_preq_s;
endpackage

// File: core/msa_ram.sv
// Dual-read byte-lane data RAM with shared word decode and per-byte write strobes.
// Assumes the caller has already removed misaligned or out-of-range writes.
`timescale 1ns/1ps
module msa_ram #(
  parameter int WORDS = msa_pkg::RAM_WORDS,
  parameter int AW = msa_pkg::RAM_AW
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic [AW-1:0] i_waddr,
  input wire logic [1:0] i_wstrb,
  input wire logic [15:0] i_wdata,
  // Read ports
  input wire logic [AW-1:0] i_raddr_x,
  input wire logic [AW-1:0] i_raddr_y,
  output logic [15:0] o_rdata_x,
  output logic [15:0] o_rdata_y
);
  logic [7:0] lo_mem [WORDS];
  logic [7:0] hi_mem [WORDS];

  always_ff @(posedge i_clk) begin
    if (i_wstrb[0]) begin
      lo_mem[i_waddr] <= i_wdata[7:0];
    end
    if (i_wstrb[1]) begin
      hi_mem[i_waddr] <= i_wdata[15:8];
    end
  end

  always_comb begin
    o_rdata_x = {hi_mem[i_raddr_x], lo_mem[i_raddr_x]};
    o_rdata_y = {hi_mem[i_raddr_y], lo_mem[i_raddr_y]};
  end
endmodule

// File: core/msa_top.sv
// Memory space access unit: data-space decode, byte lanes, traps, pointer update,
// working-register byte handling and program address generation.
// Assumes a single core clock and synchronous reset; core logic drives the requests.
`timescale 1ns/1ps
module msa_top #(
  parameter int RAM_WORDS = msa_pkg::RAM_WORDS,
  parameter logic [15:0] SPLIT = msa_pkg::XY_SPLIT
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // First space request (combined view)
  input wire msa_pkg::msa_req_s i_xreq,
  input wire msa_pkg::msa_mod_s i_xmod,
  // Second space read request
  input wire msa_pkg::msa_req_s i_yreq,
  input wire msa_pkg::msa_mod_s i_ymod,
  // Special register read data from core and peripherals
  input wire logic [15:0] i_sfr_rdata,
  input wire logic i_sfr_hit,
  // Working register update
  input wire logic [15:0] i_wreg_old,
  input wire logic [15:0] i_wreg_src,
  input wire msa_pkg::msa_wop_e i_wop,
  // Program space
  input wire logic i_pc_adv,
  input wire logic i_pc_load,
  input wire logic [22:0] i_pc_target,
  input wire msa_pkg::msa_preq_s i_preq,
  // First space outputs
  output logic [15:0] o_xrdata,
  output logic [15:0] o_xptr_next,
  output logic o_xrvalid,
  output logic o_sfr_sel,
  output logic o_sfr_we,
  output logic [1:0] o_sfr_wstrb,
  output logic [15:0] o_sfr_addr,
  output logic [15:0] o_sfr_wdata,
  // Program space window
  output logic o_window_req,
  output logic [14:0] o_window_off,
  // Second space outputs
  output logic [15:0] o_yrdata,
  output logic [15:0] o_yptr_next,
  output logic o_yrvalid,
  // Working register result
  output logic [15:0] o_wreg_new,
  // Address error
  output logic o_addr_err,
  output logic o_addr_err_wr,
  // Program addresses
  output logic [23:0] o_pc,
  output logic [23:0] o_taddr,
  output logic o_tcfg,
  output logic o_tdenied,
  output logic o_pc_in_vec
);
  function automatic logic [15:0] step_of(input logic byte_op);
    step_of = byte_op ? msa_pkg::STEP_BYTE : msa_pkg::STEP_WORD;
  endfunction

  // Pointer update with optional modulo wrap and bit-reversed carry
  function automatic logic [15:0] ptr_next(input msa_pkg::msa_req_s r,
                                           input msa_pkg::msa_mod_s m,
                                           input logic allow_rev);
    logic [15:0] nx;
    logic [msa_pkg::BITREV_W-1:0] rv;
    nx = r.ea + step_of(r.byte_op);
    rv = {<<{r.ea[msa_pkg::BITREV_W:1]}};
    rv = rv + 1'b1;
    if (allow_rev && r.bitrev_en && r.wr) begin
      nx = {r.ea[15:msa_pkg::BITREV_W+1], {<<{rv}}, r.ea[0]};
    end else if (r.modulo_en && (r.ea == m.last || r.ea + 16'h0001 == m.last)) begin
      nx = m.start;
    end
    if (!r.post_inc) begin
      nx = r.ea;
    end
    ptr_next = nx;
  endfunction

  function automatic logic [15:0] eff_addr(input msa_pkg::msa_req_s r);
    eff_addr = r.direct13 ? {3'h0, r.ea[msa_pkg::NEAR_W-1:0]} : r.ea;
  endfunction

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= msa_pkg::RAM_BASE) &&
             (a < msa_pkg::RAM_BASE + 16'(2 * RAM_WORDS));
  endfunction

  function automatic logic [msa_pkg::RAM_AW-1:0] ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - msa_pkg::RAM_BASE;
    ram_idx = d[msa_pkg::RAM_AW:1];
  endfunction

  // Byte selection onto the low lane; out-of-range reads are zero
  function automatic logic [15:0] lane(input logic [15:0] w, input logic [15:0] a,
                                       input logic byte_op);
    if (byte_op) begin
      lane = a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    end else begin
      lane = w;
    end
  endfunction

  logic [15:0] xa;
  logic [15:0] ya;
  logic x_mis;
  logic y_mis;
  logic x_sfr;
  logic x_win;
  logic x_ram;
  logic y_ram;
  logic [1:0] wstrb;
  logic [15:0] wdata_lane;
  logic [15:0] ram_x;
  logic [15:0] ram_y;

  always_comb begin
    xa = eff_addr(i_xreq);
    ya = eff_addr(i_yreq);
    x_mis = i_xreq.valid && !i_xreq.byte_op && xa[0];
    y_mis = i_yreq.valid && !i_yreq.byte_op && ya[0];
    x_win = xa[msa_pkg::WINDOW_BIT];
    x_sfr = !x_win && (xa <= msa_pkg::SFR_LAST);
    x_ram = !x_win && in_ram(xa);
    y_ram = in_ram(ya) && (ya >= SPLIT);
    wstrb = 2'h0;
    wdata_lane = i_xreq.byte_op ? {i_xreq.wdata[7:0], i_xreq.wdata[7:0]} : i_xreq.wdata;
    if (i_xreq.valid && i_xreq.wr && x_ram && !x_mis) begin
      wstrb = i_xreq.byte_op ? (xa[0] ? 2'h2 : 2'h1) : 2'h3;
    end
  end

  msa_ram #(
    .WORDS(RAM_WORDS),
    .AW(msa_pkg::RAM_AW)
  ) u_ram (
    .i_clk(i_clk),
    .i_waddr(ram_idx(xa)),
    .i_wstrb(wstrb),
    .i_wdata(wdata_lane),
    .i_raddr_x(ram_idx(xa)),
    .i_raddr_y(ram_idx(ya)),
    .o_rdata_x(ram_x),
    .o_rdata_y(ram_y)
  );

  // Data space outputs
  logic [15:0] xrdata_r, xrdata_nxt, yrdata_r, yrdata_nxt;
  logic [15:0] xptr_r, xptr_nxt, yptr_r, yptr_nxt;
  logic xrv_r, xrv_nxt, yrv_r, yrv_nxt;
  logic sfr_sel_r, sfr_sel_nxt, sfr_we_r, sfr_we_nxt;
  logic [1:0] sfr_strb_r, sfr_strb_nxt;
  logic [15:0] sfr_addr_r, sfr_addr_nxt, sfr_wd_r, sfr_wd_nxt;
  logic win_r, win_nxt;
  logic [14:0] win_off_r, win_off_nxt;
  logic err_r, err_nxt, err_wr_r, err_wr_nxt;
  logic [15:0] wreg_r, wreg_nxt;

  always_comb begin
    logic [15:0] xw;
    xw = 16'h0000;
    if (x_ram) begin
      xw = ram_x;
    end else if (x_sfr && i_sfr_hit) begin
      xw = i_sfr_rdata;
    end
    xrv_nxt = i_xreq.valid && !i_xreq.wr;
    xrdata_nxt = (xrv_nxt && !x_win) ? lane(xw, xa, i_xreq.byte_op) : 16'h0000;
    yrv_nxt = i_yreq.valid && !i_yreq.wr;
    yrdata_nxt = (yrv_nxt && y_ram) ? lane(ram_y, ya, i_yreq.byte_op) : 16'h0000;
    xptr_nxt = i_xreq.valid ? ptr_next(i_xreq, i_xmod, 1'b1) : xptr_r;
    yptr_nxt = i_yreq.valid ? ptr_next(i_yreq, i_ymod, 1'b0) : yptr_r;
    sfr_sel_nxt = i_xreq.valid && x_sfr && !(x_mis && i_xreq.wr);
    sfr_we_nxt = i_xreq.valid && i_xreq.wr && x_sfr && !x_mis;
    sfr_strb_nxt = sfr_we_nxt ? (i_xreq.byte_op ? (xa[0] ? 2'h2 : 2'h1) : 2'h3) : 2'h0;
    sfr_addr_nxt = {xa[15:1], 1'b0};
    sfr_wd_nxt = wdata_lane;
    win_nxt = i_xreq.valid && !i_xreq.wr && x_win;
    win_off_nxt = xa[14:0];
    err_nxt = x_mis || y_mis;
    err_wr_nxt = x_mis && i_xreq.wr;
    unique case (i_wop)
      msa_pkg::MSA_OP_SEXT: wreg_nxt = {{8{i_wreg_src[7]}}, i_wreg_src[7:0]};
      msa_pkg::MSA_OP_ZEXT: wreg_nxt = {8'h00, i_wreg_src[7:0]};
      msa_pkg::MSA_OP_LDB: wreg_nxt = {i_wreg_old[15:8], i_wreg_src[7:0]};
      msa_pkg::MSA_OP_LDW: wreg_nxt = i_wreg_src;
      default: wreg_nxt = i_wreg_old;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      xrdata_r <= 16'h0000;
      yrdata_r <= 16'h0000;
      xptr_r <= 16'h0000;
      yptr_r <= 16'h0000;
      xrv_r <= 1'b0;
      yrv_r <= 1'b0;
      sfr_sel_r <= 1'b0;
      sfr_we_r <= 1'b0;
      sfr_strb_r <= 2'h0;
      sfr_addr_r <= 16'h0000;
      sfr_wd_r <= 16'h0000;
      win_r <= 1'b0;
      win_off_r <= 15'h0000;
      err_r <= 1'b0;
      err_wr_r <= 1'b0;
      wreg_r <= 16'h0000;
    end else begin
      xrdata_r <= xrdata_nxt;
      yrdata_r <= yrdata_nxt;
      xptr_r <= xptr_nxt;
      yptr_r <= yptr_nxt;
      xrv_r <= xrv_nxt;
      yrv_r <= yrv_nxt;
      sfr_sel_r <= sfr_sel_nxt;
      sfr_we_r <= sfr_we_nxt;
      sfr_strb_r <= sfr_strb_nxt;
      sfr_addr_r <= sfr_addr_nxt;
      sfr_wd_r <= sfr_wd_nxt;
      win_r <= win_nxt;
      win_off_r <= win_off_nxt;
      err_r <= err_nxt;
      err_wr_r <= err_wr_nxt;
      wreg_r <= wreg_nxt;
    end
  end

  // Program address generation
  logic [23:0] pc_r, pc_nxt, taddr_r, taddr_nxt;
  logic tcfg_r, tcfg_nxt, tden_r, tden_nxt, vec_r, vec_nxt;

  always_comb begin
    pc_nxt = pc_r;
    if (i_pc_load) begin
      pc_nxt = {1'b0, i_pc_target[22:1], 1'b0};
    end else if (i_pc_adv) begin
      pc_nxt = pc_r + msa_pkg::PC_STEP;
    end
    taddr_nxt = {i_preq.page, i_preq.offset};
    tcfg_nxt = i_preq.valid && i_preq.table_op && i_preq.page[msa_pkg::TABLE_PAGE_POINTER_CFG_BIT];
    tden_nxt = i_preq.valid && !i_preq.table_op &&
               ({i_preq.page, i_preq.offset} > msa_pkg::USER_LAST);
    vec_nxt = pc_nxt < msa_pkg::VEC_END;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pc_r <= msa_pkg::RESET_VEC;
      taddr_r <= 24'h000000;
      tcfg_r <= 1'b0;
      tden_r <= 1'b0;
      vec_r <= 1'b1;
    end else begin
      pc_r <= pc_nxt;
      taddr_r <= taddr_nxt;
      tcfg_r <= tcfg_nxt;
      tden_r <= tden_nxt;
      vec_r <= vec_nxt;
    end
  end

  always_comb begin
    o_xrdata = xrdata_r;
    o_xptr_next = xptr_r;
    o_xrvalid = xrv_r;
    o_sfr_sel = sfr_sel_r;
    o_sfr_we = sfr_we_r;
    o_sfr_wstrb = sfr_strb_r;
    o_sfr_addr = sfr_addr_r;
    o_sfr_wdata = sfr_wd_r;
    o_window_req = win_r;
    o_window_off = win_off_r;
    o_yrdata = yrdata_r;
    o_yptr_next = yptr_r;
    o_yrvalid = yrv_r;
    o_wreg_new = wreg_r;
    o_addr_err = err_r;
    o_addr_err_wr = err_wr_r;
    o_pc = pc_r;
    o_taddr = taddr_r;
    o_tcfg = tcfg_r;
    o_tdenied = tden_r;
    o_pc_in_vec = vec_r;
  end

  AST_MIS_ERR: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_xreq.valid && !i_xreq.byte_op && xa[0]) |=> o_addr_err)
    else $error("misaligned word access gave no address error");
  AST_ERR_PULSE: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_addr_err && !$past(x_mis || y_mis)) |-> 1'b0)
    else $error("address error without cause");
  AST_WR_SUPP: assert property (@(posedge i_clk) disable iff (i_srst)
    x_mis |-> (wstrb == 2'h0) ##1 !o_sfr_we)
    else $error("misaligned write not suppressed");
  AST_BYTE_STRB: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_xreq.valid && i_xreq.wr && i_xreq.byte_op && x_ram) |-> (wstrb == (xa[0] ? 2'h2 : 2'h1)))
    else $error("byte write strobe wrong lane");
  AST_STEP: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_xreq.valid && i_xreq.post_inc && !i_xreq.modulo_en && !i_xreq.bitrev_en)
    |=> o_xptr_next == $past(i_xreq.ea) + (($past(i_xreq.byte_op)) ? 16'h0001 : 16'h0002))
    else $error("pointer step not scaled by size");
  AST_ZERO_RD: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_xreq.valid && !i_xreq.wr && !x_ram && !(x_sfr && i_sfr_hit)) |=> o_xrdata == 16'h0000)
    else $error("unimplemented read not zero");
  AST_BYTE_HI: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_xreq.valid && !i_xreq.wr && i_xreq.byte_op) |=> o_xrdata[15:8] == 8'h00)
    else $error("byte read not on low lane");
  AST_LDB: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_wop == msa_pkg::MSA_OP_LDB) |=> o_wreg_new[15:8] == $past(i_wreg_old[15:8]))
    else $error("byte load changed high byte");
  AST_PC_STEP: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_pc_adv && !i_pc_load) |=> o_pc == $past(o_pc) + 24'h000002)
    else $error("program counter did not step by two");
  AST_WIN: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_xreq.valid && !i_xreq.wr && xa[15]) |=> o_window_req && !o_sfr_sel)
    else $error("upper half not routed to window");
endmodule
